/* File: host_dma_sink.sv */
/*
  Host DMA sink model: accepts host beats with random stalls.
  Assumes the design's clock and reset; seed set by the testbench.
*/
`timescale 1ns/1ps

module host_dma_sink (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // Stall percentage, 100 holds ready low
  input  wire logic [7:0] stall_pct,
  // Host stream handshake
  output logic            host_ready
);
  // ----------------------------------------------------------------
  // Ready pattern
  // ----------------------------------------------------------------
  // Host pulls payload and stamp over DMA
  always @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      host_ready <= 1'b0;
    else
      host_ready <= #1 (($urandom % 100) >= stall_pct);
  end
endmodule

/* File: ingress_timestamp_path.sv */
/*
  Ingress timestamp path: event FIFO with EtherType trigger and per-packet
  host timestamping in front of the internal port FIFO.
  Assumes inputs synchronous to ref_clk; a frame's sof beat carries the
  EtherType in its low 16 bits; preamble_ok comes from the receive MAC.
*/
`timescale 1ns/1ps

`include "ingress_ts_params.svh"

module ingress_timestamp_path
#(
  parameter int DEPTH     = `PORT_FIFO_DEPTH,
  parameter int EVT_DEPTH = `EVT_FIFO_DEPTH,
  parameter bit FIX_EN    = 1'b1  // 0 reproduces the lost-request defect
) (
  // Clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  // Control
  input  wire logic                       host_stamp_en,
  input  wire logic                       event_en,
  input  wire logic [`ETYPE_WIDTH-1:0]    etype_match,
  // Receive stream from MAC
  input  wire ingress_ts_pkg::beat_t      rx_beat,
  input  wire logic                       rx_valid,
  input  wire logic                       preamble_ok,
  output logic                            rx_ready,
  // Host DMA stream
  output ingress_ts_pkg::host_beat_t      host_beat,
  output logic                            host_valid,
  input  wire logic                       host_ready,
  // Event FIFO read port
  output ingress_ts_pkg::event_t          evt_data,
  output logic                            evt_valid,
  input  wire logic                       evt_pop,
  // Status
  output logic                            stalled
);
  import ingress_ts_pkg::*;

  initial
  begin
    // Wrap-bit pointers need power-of-two depths
    if (DEPTH < 2 || (1 << $clog2(DEPTH)) != DEPTH)
      $error("ingress_timestamp_path: DEPTH must be a power of two");
    if (EVT_DEPTH < 2 || EVT_DEPTH > 256 ||
        (1 << $clog2(EVT_DEPTH)) != EVT_DEPTH)
      $error("ingress_timestamp_path: EVT_DEPTH out of range");
  end

  localparam int EAW = $clog2(EVT_DEPTH);

  // ----------------------------------------------------------------
  // Free-running time counter
  // ----------------------------------------------------------------
  logic [`TS_WIDTH-1:0] time_r;
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      time_r <= `TIME_RESET;
    else
      time_r <= time_r + 1'b1;
  end

  // ----------------------------------------------------------------
  // Port FIFO in the data path
  // ----------------------------------------------------------------
  localparam int           BW      = $bits(beat_t);
  localparam int           PAW     = $clog2(DEPTH);
  localparam logic [PAW:0] DEPTH_W = (PAW+1)'(DEPTH); // Full level
  logic         fifo_in_ready;   // FIFO has room
  logic         fifo_out_valid;  // FIFO head present
  logic         fifo_out_ready;  // Head leaves this cycle
  beat_t        fifo_out;        // Head beat
  logic [PAW:0] occ_r;           // Beats held in the port FIFO
  wire          rx_take = rx_valid && rx_ready;

  stream_fifo #(.WIDTH(BW), .DEPTH(DEPTH)) u_port_fifo (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .in_valid  (rx_take),
    .in_ready  (fifo_in_ready),
    .in_data   (rx_beat),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out)
  );

  // Occupancy after this edge, so ready can come from a flop
  wire [PAW:0] occ_nxt = occ_r + {{PAW{1'b0}}, rx_take} -
                         {{PAW{1'b0}}, fifo_out_ready};

  // Registered ready: room for one more beat after this edge
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      occ_r    <= '0;
      rx_ready <= 1'b1;
    end
    else
    begin
      occ_r    <= occ_nxt;
      rx_ready <= (occ_nxt != DEPTH_W); // see (RULE4)
    end
  end

  // Admission and timestamp request at the sof beat
  wire admit_sof = rx_take && rx_beat.sof;
  // Defect model drops the request on a bad preamble
  wire ts_req = admit_sof && (FIX_EN || preamble_ok); // see (RULE6) (RULE8)

  // ----------------------------------------------------------------
  // Timestamp queue: one entry per requested frame
  // ----------------------------------------------------------------
  logic [`TS_WIDTH-1:0] tsq [DEPTH];
  logic [$clog2(DEPTH):0] tq_wr_r;
  logic [$clog2(DEPTH):0] tq_rd_r;
  wire tq_empty = (tq_wr_r == tq_rd_r);
  logic tq_pop;

  // Timestamp capture per request
  always_ff @(posedge ref_clk)
  begin
    if (ts_req)
      tsq[tq_wr_r[$clog2(DEPTH)-1:0]] <= time_r; // see (RULE3)
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      tq_wr_r <= '0;
      tq_rd_r <= '0;
    end
    else
    begin
      if (ts_req)
        tq_wr_r <= tq_wr_r + 1'b1;
      if (tq_pop)
        tq_rd_r <= tq_rd_r + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Output stage: sof waits for its timestamp when stamping on
  // ----------------------------------------------------------------
  wire head_sof  = fifo_out_valid && fifo_out.sof;
  wire need_ts   = host_stamp_en && head_sof; // see (RULE4) (RULE5)
  wire ts_ready  = !tq_empty;
  wire out_free  = !host_valid || host_ready;
  wire can_move  = fifo_out_valid && out_free && (!need_ts || ts_ready);
  assign fifo_out_ready = can_move;
  // Stamp entries are consumed on every sof, stamped or not
  assign tq_pop = can_move && fifo_out.sof && ts_ready;

  // Registered host output
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      host_valid <= 1'b0;
      host_beat  <= '0;
      stalled    <= 1'b0;
    end
    else
    begin
      stalled <= need_ts && !ts_ready;
      if (can_move)
      begin
        host_valid           <= 1'b1;
        host_beat.beat       <= fifo_out;
        host_beat.stamp      <= tsq[tq_rd_r[$clog2(DEPTH)-1:0]];
        host_beat.stamped    <= need_ts; // see (RULE3)
      end
      else if (host_ready)
        host_valid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Event FIFO: EtherType-triggered capture
  // ----------------------------------------------------------------
  event_t evq [EVT_DEPTH];
  logic [EAW:0] ev_wr_r;
  logic [EAW:0] ev_rd_r;
  wire ev_full  = (ev_wr_r[EAW] != ev_rd_r[EAW]) &&
                  (ev_wr_r[EAW-1:0] == ev_rd_r[EAW-1:0]);
  wire ev_hit   = event_en && admit_sof &&
                  (rx_beat.data[`ETYPE_WIDTH-1:0] == etype_match);
  wire ev_push  = ev_hit && !ev_full; // see (RULE1)
  wire ev_do_pop = evt_pop && evt_valid;
  // Read pointer after this edge's pop
  wire [EAW:0] ev_rd_nxt = ev_rd_r + {{EAW{1'b0}}, ev_do_pop};

  always_ff @(posedge ref_clk)
  begin
    if (ev_push)
      evq[ev_wr_r[EAW-1:0]] <= '{stamp: time_r, etype: etype_match};
  end

  // Event pointers and registered read port
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ev_wr_r   <= '0;
      ev_rd_r   <= '0;
      evt_valid <= 1'b0;
      evt_data  <= '0;
    end
    else
    begin
      if (ev_push)
        ev_wr_r <= ev_wr_r + 1'b1;
      if (ev_do_pop)
        ev_rd_r <= ev_rd_r + 1'b1;
      // Head follows this edge's pop at once; a new push shows one cycle after the write pointer moves
      evt_valid <= (ev_wr_r != ev_rd_nxt);
      evt_data  <= evq[ev_rd_nxt[EAW-1:0]];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Every admitted frame queues exactly one stamp
  AST_ONE_REQ_PER_SOF: assert property ( // see (RULE8)
    @(posedge ref_clk) disable iff (rst)
    FIX_EN |-> ##1 (tq_wr_r == $past(tq_wr_r) + $past(admit_sof)))
    else $error("Timestamp request not tied to admission");
  AST_EVENT_CAPTURE: assert property ( // see (RULE1)
    @(posedge ref_clk) disable iff (rst)
    ev_hit && !ev_full |=> ev_wr_r == $past(ev_wr_r) + 1'b1)
    else $error("Matching frame not captured");
  AST_STAMP_ATTACHED: assert property ( // see (RULE3)
    @(posedge ref_clk) disable iff (rst)
    can_move && need_ts |=> host_valid && host_beat.stamped)
    else $error("Host beat missing its stamp");
  AST_WAIT_FOR_STAMP: assert property ( // see (RULE4)
    @(posedge ref_clk) disable iff (rst)
    need_ts && tq_empty |-> !fifo_out_ready)
    else $error("Frame passed without timestamp");
  AST_NO_WAIT_DISABLED: assert property ( // see (RULE5)
    @(posedge ref_clk) disable iff (rst)
    !host_stamp_en && fifo_out_valid && out_free |-> fifo_out_ready)
    else $error("Port stalls with stamping off");
  AST_STALL_FLAG: assert property ( // see (RULE6)
    @(posedge ref_clk) disable iff (rst)
    need_ts && !ts_ready |=> stalled)
    else $error("Stall not reported");
  // Corrected path never leaves a head frame without its stamp
  AST_NO_LOCKUP: assert property ( // see (RULE6)
    @(posedge ref_clk) disable iff (rst)
    FIX_EN && need_ts |-> ts_ready)
    else $error("Head frame lacks its timestamp");
  AST_EVT_COUNT: assert property ( // see (RULE1)
    @(posedge ref_clk) disable iff (rst)
    ev_do_pop |=> ev_rd_r == $past(ev_rd_r) + 1'b1)
    else $error("Event pop lost");
  AST_TQ_BOUND: assert property ( // see (RULE8)
    @(posedge ref_clk) disable iff (rst)
    (tq_wr_r - tq_rd_r) <= DEPTH_W)
    else $error("Timestamp queue overrun");
  // Registered ready never offers room the FIFO lacks
  AST_READY_SAFE: assert property ( // see (RULE4)
    @(posedge ref_clk) disable iff (rst)
    rx_ready |-> fifo_in_ready)
    else $error("Ready raised while port FIFO full");

  COV_STAMPED: cover property (@(posedge ref_clk) disable iff (rst)
    can_move && need_ts);
  COV_EVENT: cover property (@(posedge ref_clk) disable iff (rst) ev_push);
  COV_STALL: cover property (@(posedge ref_clk) disable iff (rst)
    stalled ##1 !stalled);
  COV_BAD_PREAMBLE: cover property (@(posedge ref_clk) disable iff (rst)
    admit_sof && !preamble_ok);

endmodule

/* File: ingress_ts_params.svh */
/*
  Constants for the ingress timestamp path: field widths, reset values.
  Assumes inclusion by bare name from the package and the modules.
*/
// Summary of operation
// (RULE1) Event FIFO captures timestamp on EtherType match
// (RULE2) Host fetches event timestamps, payload via DMA
// (RULE3) Host stamping attaches timestamp to every packet
// (RULE4) Each packet waits for its timestamp
// (RULE5) Clearing host-stamp enable removes the wait
// (RULE6) Corrupted preamble may skip timestamp request
// (RULE7) Host keeps per-packet stamping disabled
// (RULE8) Exactly one request per admitted frame
`ifndef INGRESS_TS_PARAMS_SVH
`define INGRESS_TS_PARAMS_SVH

// ----------------------------------------------------------------
// Widths and defaults
// ----------------------------------------------------------------
`define TS_WIDTH        64
`define DATA_WIDTH      32
`define ETYPE_WIDTH     16
`define PORT_FIFO_DEPTH 16
`define EVT_FIFO_DEPTH  16
`define TIME_RESET      64'h0000_0000_0000_0000
`define ETYPE_RESET     16'h88f7

`endif

/* File: ingress_ts_pkg.sv */
/*
  Types shared by the ingress timestamp path.
  Assumes ingress_ts_params.svh is on the include path.
*/
`include "ingress_ts_params.svh"

package ingress_ts_pkg;

  // ----------------------------------------------------------------
  // Stream beat of frame data
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [`DATA_WIDTH-1:0] data;  // Payload word
    logic                   sof;   // First word of frame
    logic                   eof;   // Last word of frame
  } beat_t;

  // ----------------------------------------------------------------
  // Captured event record
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [`TS_WIDTH-1:0]    stamp; // Time of arrival
    logic [`ETYPE_WIDTH-1:0] etype; // Matching EtherType
  } event_t;

  // Host-side output beat, timestamp rides with first word
  typedef struct packed {
    beat_t                beat;  // Payload word
    logic [`TS_WIDTH-1:0] stamp; // Receive timestamp
    logic                 stamped; // Stamp field valid
  } host_beat_t;

  // Ingress per-frame state
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WAIT  = 2'b01,
    ST_PASS  = 2'b11
  } egress_state_t;

endpackage

/* File: stream_fifo.sv */
/*
  Parameterised valid/ready FIFO.
  Assumes one clock, asynchronous active-high reset.
*/
`timescale 1ns/1ps

module stream_fifo #(
  parameter int WIDTH = 34,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int AW = $clog2(DEPTH);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
      $error("stream_fifo: DEPTH must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];  // Storage array
  logic [AW:0]      wr_ptr_r;     // Write pointer with wrap bit
  logic [AW:0]      rd_ptr_r;     // Read pointer with wrap bit

  // Full and empty from pointer compare
  wire empty = (wr_ptr_r == rd_ptr_r);
  wire full  = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
               (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  wire push  = in_valid && !full;
  wire pop   = !empty && out_ready;

  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr_r[AW-1:0]];

  // Storage write
  always_ff @(posedge ref_clk)
  begin
    if (push)
      mem[wr_ptr_r[AW-1:0]] <= in_data;
  end

  // Pointer update
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end

  // Fill level never passes the depth
  AST_NO_OVERFLOW: assert property (@(posedge ref_clk) disable iff (rst)
    (AW+1)'(wr_ptr_r - rd_ptr_r) <= (AW+1)'(DEPTH))
    else $error("FIFO accepts while full");

endmodule

/* File: tb_ingress_timestamp_path.sv */
/*
  Self-checking bench of the ingress timestamp path.
  Assumes host_dma_sink.sv and the design files are compiled first.
*/
`timescale 1ns/1ps

`include "ingress_ts_params.svh"

module tb_ingress_timestamp_path;
  import ingress_ts_pkg::*;
  logic             ref_clk = 1'b0;
  logic             rst = 1'b1;
  logic             host_stamp_en = 1'b0;
  logic             event_en = 1'b0;
  logic [15:0]      etype_match = `ETYPE_RESET;
  beat_t            rx_beat = '0;
  logic             rx_valid = 1'b0;
  logic             preamble_ok = 1'b1;
  logic             rx_ready;
  host_beat_t       host_beat;
  logic             host_valid;
  logic             host_ready;
  event_t           evt_data;
  logic             evt_valid;
  logic             evt_pop = 1'b0;
  logic             stalled;
  logic [7:0]       stall_pct = 8'd30;
  logic [63:0]      cyc;      // Time counter mirror
  int               acc_n;    // Accepted beats
  int               fails = 0;
  int               checks_done = 0;
  int               acc_base; // Accepted count at scenario start
  host_beat_t       exp_q[$];
  event_t           evt_q[$];
  host_beat_t       e;
  event_t           v;

  // 200 MHz clock
  always #2.5 ref_clk = ~ref_clk;

  ingress_timestamp_path i_ingress_timestamp_path (
    .ref_clk(ref_clk), .rst(rst), .host_stamp_en(host_stamp_en),
    .event_en(event_en), .etype_match(etype_match), .rx_beat(rx_beat),
    .rx_valid(rx_valid), .preamble_ok(preamble_ok), .rx_ready(rx_ready),
    .host_beat(host_beat), .host_valid(host_valid),
    .host_ready(host_ready), .evt_data(evt_data), .evt_valid(evt_valid),
    .evt_pop(evt_pop), .stalled(stalled));

  host_dma_sink i_host_dma_sink (
    .ref_clk(ref_clk), .rst(rst), .stall_pct(stall_pct),
    .host_ready(host_ready));

  // Compare and count
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Wait for ready between edges, then let the taking edge pass
  task automatic wait_accept();
    int k;
    for (k = 0; k < 2000 && rx_ready !== 1'b1; k++)
    begin
      @(posedge ref_clk);
      #1;
    end
    check(rx_ready, 1'b1);
    @(posedge ref_clk);
    #1;
  endtask

  // One frame, EtherType in the low half of the first word
  task automatic send_frame(input int len, input logic [15:0] et,
                            input logic pre);
    int n;
    for (n = 0; n < len; n++)
    begin
      rx_beat.data = $urandom;
      if (n == 0)
        rx_beat.data[15:0] = et;
      rx_beat.sof = (n == 0);
      rx_beat.eof = (n == len - 1);
      preamble_ok = pre;
      rx_valid = 1'b1;
      wait_accept();
    end
    rx_valid = 1'b0;
    @(posedge ref_clk);
    #1;
  endtask

  // Random frames with a mix of matching types and bad preambles
  task automatic frames(input int cnt);
    int f;
    for (f = 0; f < cnt; f++)
      send_frame(1 + $urandom % 4, ($urandom % 2) ? etype_match : $urandom,
                 $urandom % 2);
  endtask

  // Bounded wait until all notes are consumed
  task automatic drain();
    int k;
    for (k = 0; k < 3000 && (exp_q.size() + evt_q.size()) > 0; k++)
    begin
      @(posedge ref_clk);
      #1;
    end
  endtask

  // Driver side notes: expected beat at each accepted beat, event at each matching sof
  always @(posedge ref_clk)
  begin
    cyc <= rst ? 64'h0 : cyc + 64'h1;
    if (!rst && rx_valid && rx_ready)
    begin
      acc_n++;
      exp_q.push_back(host_beat_t'{beat: rx_beat, stamp: cyc,
                                   stamped: host_stamp_en && rx_beat.sof});
      if (rx_beat.sof && event_en && rx_beat.data[15:0] == etype_match)
        evt_q.push_back(event_t'{stamp: cyc, etype: etype_match});
    end
  end

  // Output watcher: host beats
  always @(posedge ref_clk)
  begin
    if (!rst && host_valid && host_ready)
    begin
      if (exp_q.size() == 0)
        check(64'h1, 64'h0);
      else
      begin
        e = exp_q.pop_front();
        check(host_beat.beat, e.beat);
        check(host_beat.stamped, e.stamped);
        if (e.stamped && e.beat.sof)
          check(host_beat.stamp, e.stamp);
      end
    end
  end

  // Output watcher: event records, random pops
  always @(posedge ref_clk)
  begin
    if (!rst && evt_valid && evt_pop)
    begin
      v = (evt_q.size() > 0) ? evt_q.pop_front() : '1;
      check(evt_data.stamp, v.stamp);
      check(evt_data.etype, v.etype);
    end
    evt_pop <= #1 $urandom % 2;
  end

  // Watchdog
  initial
  begin
    #100000;
    fails++;
    summarize();
  end

  // Main sequence
  initial
  begin
    void'($urandom(86137));
    repeat (2) @(posedge ref_clk);
    #1 rst = 1'b0;
    // Stamping and event capture, bad preambles mixed in
    host_stamp_en = 1'b1;
    event_en = 1'b1;
    frames(12);
    // Far side stalls until the port FIFO refuses
    drain();
    stall_pct = 8'd100;
    acc_base = acc_n;
    fork
      send_frame(24, etype_match, 1'b0);
    join_none
    repeat (80) @(posedge ref_clk);
    #1;
    check(rx_ready, 1'b0);
    check(acc_n - acc_base >= 16, 1'b1);
    stall_pct = 8'd20;
    wait fork;
    drain();
    // Host keeps per-packet stamping off; events captured for 8 frames, then event_en cleared
    host_stamp_en = 1'b0;
    etype_match = $urandom;
    frames(8);
    event_en = 1'b0;
    frames(6);
    drain();
    repeat (10) @(posedge ref_clk);
    #1;
    check(stalled, 1'b0);
    check(exp_q.size() + evt_q.size(), 0);
    summarize();
  end
endmodule
